//--- include/rfcs_pkg.sv
package rfcs_pkg;
    // register indices; byte address is four times the index
    localparam logic [8:0] IDX_FIFO_CTRL = 9'h087;
    localparam logic [8:0] IDX_ILV_CTRL = 9'h088;
    localparam logic [8:0] IDX_SPARE_LEN = 9'h089;
    localparam logic [8:0] IDX_XPC_CTRL = 9'h08a;
    localparam logic [8:0] IDX_BERT_MASK = 9'h08b;
    localparam logic [8:0] IDX_HDLC_MASK = 9'h08d;
    localparam logic [8:0] IDX_STATUS1 = 9'h090;
    localparam logic [8:0] IDX_STATUS2 = 9'h091;
    localparam int PORT_STRIDE_IDX = 'h200;
    localparam int APB_ADDR_W = 14;
    localparam int PORT_LSB = 11;
    localparam int IDX_LSB = 2;
    // writable field masks
    localparam logic [7:0] MASK_FIFO = 8'h03;
    localparam logic [7:0] MASK_ILV = 8'h18;
    localparam logic [7:0] MASK_SPARE = 8'h07;
    localparam logic [7:0] MASK_XPC = 8'hc7;
    localparam logic [7:0] MASK_STATUS2 = 8'h3f;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // field positions
    localparam int ILV_KIND_BIT = 4;
    localparam int ILV_ON_BIT = 3;
    localparam int XPC_ASSIGN_BIT = 7;
    localparam int XPC_HDLC_ON_BIT = 6;
    localparam int XPC_DIR_BIT = 2;
    localparam int XPC_FRAMING_BIT = 1;
    localparam int XPC_BERT_ON_BIT = 0;
    localparam int ST2_ALIGN_BIT = 5;
    localparam int ST2_Z8_BIT = 4;
    localparam int ST2_Z16_BIT = 3;
    localparam int ST2_SEF_BIT = 2;
    localparam int ST2_B8ZS_BIT = 1;
    localparam int ST2_FBE_BIT = 0;
    // thresholds
    localparam logic [5:0] WM_CODE0 = 6'h04;
    localparam logic [5:0] WM_CODE1 = 6'h10;
    localparam logic [5:0] WM_CODE2 = 6'h20;
    localparam logic [5:0] WM_CODE3 = 6'h30;
    localparam logic [4:0] SPARE_VAR_MIN = 5'h08;
    localparam logic [7:0] LOS_ZEROS = 8'hc0;
    localparam logic [7:0] ZRUN_SHORT = 8'h08;
    localparam logic [7:0] ZRUN_LONG = 8'h10;
    localparam int SEF_WINDOW = 6;
    localparam logic [2:0] SEF_ERRORS = 3'h2;
    localparam logic [1:0] SYM_POS = 2'b10;
endpackage : rfcs_pkg

//--- rtl/rfcs_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rfcs_regs
    import rfcs_pkg::*;
#(
    parameter int NP = 8,
    parameter int AIS_RUN = 2048
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NP-1:0] t1_mode,
    input wire logic [NP-1:0] line_rx_pos,
    input wire logic [NP-1:0] line_rx_neg,
    input wire logic [NP-1:0] line_bit_tick,
    input wire logic [NP-1:0] remote_alarm_cond,
    input wire logic [NP-1:0] frame_loss_cond,
    input wire logic [NP-1:0] fbit_tick,
    input wire logic [NP-1:0] fbit_err,
    input wire logic [NP-1:0] align_change,
    output logic [NP-1:0][5:0] fifo_wm_bytes,
    output logic [NP-1:0] interleave_on,
    output logic [NP-1:0] interleave_kind_sel,
    output logic [NP-1:0][4:0] spare_code_length,
    output logic [NP-1:0] spare_len_var,
    output logic [NP-1:0] hdlc256_on,
    output logic [NP-1:0] hdlc256_fdl,
    output logic [NP-1:0] hdlc256_sa,
    output logic [NP-1:0] bert_port_on,
    output logic [NP-1:0] bert_direction,
    output logic [NP-1:0] bert_incl_fbit,
    output logic [NP-1:0][7:0] bert_bit_use,
    output logic [NP-1:0][7:0] hdlc_bit_use,
    output logic [NP-1:0] status1_pending,
    output logic [NP-1:0] signal_loss,
    output logic [NP-1:0] all_ones_alarm
);

    function automatic logic [5:0] wm_fn(input logic [1:0] code);
        case (code)
            2'b00: wm_fn = WM_CODE0;
            2'b01: wm_fn = WM_CODE1;
            2'b10: wm_fn = WM_CODE2;
            default: wm_fn = WM_CODE3;
        endcase
    endfunction : wm_fn
    function automatic logic [2:0] pop6_fn(input logic [5:0] v);
        pop6_fn = 3'h0;
        for (int i = 0; i < SEF_WINDOW; i++) begin
            pop6_fn = pop6_fn + {2'b00, v[i]};
        end
    endfunction : pop6_fn

    // ==========================================================
    // apb slave
    // ==========================================================
    logic [NP-1:0][7:0] fifo_reg, ilv_reg, spare_reg, xpc_reg;
    logic [NP-1:0][7:0] bmask_reg, hmask_reg, st1_reg, st2_reg;
    logic [NP-1:0][7:0] st1_next, st2_next, ev1, ev2;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    logic [2:0] port_sel;
    logic [8:0] idx;
    logic hit, commit, wr_go;
    logic [7:0] rd_val;

    always_comb begin
        port_sel = paddr[PORT_LSB+2:PORT_LSB];
        idx = paddr[PORT_LSB-1:IDX_LSB];
        hit = (paddr[1:0] == 2'b00) && (32'(port_sel) < NP) &&
            (idx == IDX_FIFO_CTRL || idx == IDX_ILV_CTRL ||
             idx == IDX_SPARE_LEN || idx == IDX_XPC_CTRL ||
             idx == IDX_BERT_MASK || idx == IDX_HDLC_MASK ||
             idx == IDX_STATUS1 || idx == IDX_STATUS2);
        rd_val = 8'h00;
        if (hit) begin
            case (idx)
                IDX_FIFO_CTRL: rd_val = fifo_reg[port_sel];
                IDX_ILV_CTRL: rd_val = ilv_reg[port_sel];
                IDX_SPARE_LEN: rd_val = spare_reg[port_sel];
                IDX_XPC_CTRL: rd_val = xpc_reg[port_sel];
                IDX_BERT_MASK: rd_val = bmask_reg[port_sel];
                IDX_HDLC_MASK: rd_val = hmask_reg[port_sel];
                IDX_STATUS1: rd_val = st1_reg[port_sel];
                IDX_STATUS2: rd_val = st2_reg[port_sel];
                default: rd_val = 8'h00;
            endcase
        end
        commit = psel && penable && pready_reg;
        wr_go = commit && pwrite && hit;
    end

    // one wait state: answer in the second access cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !hit;
            if (psel && penable && !pready_reg) begin
                prdata_reg <= {24'h00_0000, rd_val};
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ==========================================================
    // control registers
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fifo_reg <= '0;
            ilv_reg <= '0;
            spare_reg <= '0;
            xpc_reg <= '0;
            bmask_reg <= '0;
            hmask_reg <= '0;
        end else if (wr_go) begin
            case (idx)
                IDX_FIFO_CTRL: fifo_reg[port_sel] <= pwdata[7:0] & MASK_FIFO;
                IDX_ILV_CTRL: ilv_reg[port_sel] <= pwdata[7:0] & MASK_ILV;
                IDX_SPARE_LEN:
                    spare_reg[port_sel] <= pwdata[7:0] & MASK_SPARE;
                IDX_XPC_CTRL: xpc_reg[port_sel] <= pwdata[7:0] & MASK_XPC;
                IDX_BERT_MASK: bmask_reg[port_sel] <= pwdata[7:0];
                IDX_HDLC_MASK: hmask_reg[port_sel] <= pwdata[7:0];
                default: fifo_reg <= fifo_reg;
            endcase
        end
    end

    // ==========================================================
    // decoded control outputs
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fifo_wm_bytes <= '0;
            interleave_on <= '0;
            interleave_kind_sel <= '0;
            spare_code_length <= '0;
            spare_len_var <= '0;
            hdlc256_on <= '0;
            hdlc256_fdl <= '0;
            hdlc256_sa <= '0;
            bert_port_on <= '0;
            bert_direction <= '0;
            bert_incl_fbit <= '0;
            bert_bit_use <= '0;
            hdlc_bit_use <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                fifo_wm_bytes[p] <= wm_fn(fifo_reg[p][1:0]);
                interleave_kind_sel[p] <= ilv_reg[p][ILV_KIND_BIT];
                interleave_on[p] <= ilv_reg[p][ILV_ON_BIT];
                if (spare_reg[p][2:0] == 3'b111) begin
                    spare_code_length[p] <= SPARE_VAR_MIN;
                    spare_len_var[p] <= 1'b1;
                end else begin
                    spare_code_length[p] <= {2'b00, spare_reg[p][2:0]} + 5'h01;
                    spare_len_var[p] <= 1'b0;
                end
                hdlc256_fdl[p] <= xpc_reg[p][XPC_ASSIGN_BIT] && t1_mode[p];
                hdlc256_sa[p] <= xpc_reg[p][XPC_ASSIGN_BIT] && !t1_mode[p];
                hdlc256_on[p] <= xpc_reg[p][XPC_HDLC_ON_BIT];
                bert_direction[p] <= xpc_reg[p][XPC_DIR_BIT];
                bert_incl_fbit[p] <= xpc_reg[p][XPC_FRAMING_BIT] &&
                    t1_mode[p];
                bert_port_on[p] <= xpc_reg[p][XPC_BERT_ON_BIT];
                bert_bit_use[p] <= ~bmask_reg[p];
                hdlc_bit_use[p] <= ~hmask_reg[p];
            end
        end
    end

    // ==========================================================
    // line monitor
    // ==========================================================
    logic [NP-1:0] pos_s1, pos_s2, neg_s1, neg_s2, tick_d1, tick_d2;
    logic [NP-1:0][7:0] zrun_reg;
    logic [NP-1:0][11:0] orun_reg;
    logic [NP-1:0][15:0] hist_reg;
    logic [NP-1:0][1:0] pol_reg;
    logic [NP-1:0][5:0] fwin_reg;
    logic [NP-1:0][3:0] cond_prev_reg;
    logic [NP-1:0] los_reg, ais_reg;
    logic [NP-1:0][1:0] sym, prev_mark;
    logic [NP-1:0][15:0] hist_new;
    logic [NP-1:0][3:0] cond_now;
    logic [NP-1:0] is_zero, b8zs_ev, sef_ev;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pos_s1 <= '0;
            pos_s2 <= '0;
            neg_s1 <= '0;
            neg_s2 <= '0;
            tick_d1 <= '0;
            tick_d2 <= '0;
        end else begin
            pos_s1 <= line_rx_pos;
            pos_s2 <= pos_s1;
            neg_s1 <= line_rx_neg;
            neg_s2 <= neg_s1;
            tick_d1 <= line_bit_tick;
            tick_d2 <= tick_d1;
        end
    end

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            sym[p] = pos_s2[p] ? SYM_POS : {1'b0, neg_s2[p]};
            is_zero[p] = (sym[p] == 2'b00);
            hist_new[p] = {hist_reg[p][13:0], sym[p]};
            prev_mark[p] = (hist_reg[p][15:14] != 2'b00) ?
                hist_reg[p][15:14] : pol_reg[p];
            // 000VB0VB relative to the mark before the window
            b8zs_ev[p] = tick_d2[p] && hist_new[p][15:10] == 6'h00 &&
                hist_new[p][9:8] == prev_mark[p] &&
                hist_new[p][7:6] == ~prev_mark[p] &&
                hist_new[p][5:4] == 2'b00 &&
                hist_new[p][3:2] == ~prev_mark[p] &&
                hist_new[p][1:0] == prev_mark[p];
            sef_ev[p] = fbit_tick[p] && fbit_err[p] &&
                pop6_fn({fwin_reg[p][4:0], 1'b1}) >= SEF_ERRORS;
            cond_now[p] = {remote_alarm_cond[p], ais_reg[p], los_reg[p],
                frame_loss_cond[p]};
            ev1[p] = {cond_prev_reg[p] & ~cond_now[p],
                cond_now[p] & ~cond_prev_reg[p]};
            ev2[p] = 8'h00;
            ev2[p][ST2_ALIGN_BIT] = align_change[p];
            ev2[p][ST2_Z8_BIT] = tick_d2[p] && is_zero[p] &&
                zrun_reg[p] == ZRUN_SHORT - 8'h01;
            ev2[p][ST2_Z16_BIT] = tick_d2[p] && is_zero[p] &&
                zrun_reg[p] == ZRUN_LONG - 8'h01;
            ev2[p][ST2_SEF_BIT] = sef_ev[p];
            ev2[p][ST2_B8ZS_BIT] = b8zs_ev[p];
            ev2[p][ST2_FBE_BIT] = fbit_tick[p] && fbit_err[p];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            zrun_reg <= '0;
            orun_reg <= '0;
            hist_reg <= '0;
            pol_reg <= {NP{SYM_POS}};
            los_reg <= '0;
            ais_reg <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (tick_d2[p]) begin
                    hist_reg[p] <= hist_new[p];
                    pol_reg[p] <= prev_mark[p];
                    if (is_zero[p]) begin
                        if (zrun_reg[p] != 8'hff) begin
                            zrun_reg[p] <= zrun_reg[p] + 8'h01;
                        end
                        orun_reg[p] <= 12'h000;
                        ais_reg[p] <= 1'b0;
                        if (zrun_reg[p] == LOS_ZEROS - 8'h01) begin
                            los_reg[p] <= 1'b1;
                        end
                    end else begin
                        zrun_reg[p] <= 8'h00;
                        los_reg[p] <= 1'b0;
                        if (orun_reg[p] != 12'hfff) begin
                            orun_reg[p] <= orun_reg[p] + 12'h001;
                        end
                        if (orun_reg[p] == 12'(AIS_RUN - 1)) begin
                            ais_reg[p] <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            fwin_reg <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (fbit_tick[p]) begin
                    fwin_reg[p] <= {fwin_reg[p][4:0], fbit_err[p]};
                end
            end
        end
    end

    // ==========================================================
    // latched status
    // ==========================================================
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            st1_next[p] = st1_reg[p];
            st2_next[p] = st2_reg[p];
            if (wr_go && 32'(port_sel) == p && idx == IDX_STATUS1) begin
                st1_next[p] = st1_reg[p] & ~pwdata[7:0];
            end
            if (wr_go && 32'(port_sel) == p && idx == IDX_STATUS2) begin
                st2_next[p] = st2_reg[p] & ~pwdata[7:0];
            end
            st1_next[p] = st1_next[p] | ev1[p];
            st2_next[p] = (st2_next[p] | ev2[p]) & MASK_STATUS2;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st1_reg <= '0;
            st2_reg <= '0;
            cond_prev_reg <= '0;
            status1_pending <= '0;
            signal_loss <= '0;
            all_ones_alarm <= '0;
        end else begin
            st1_reg <= st1_next;
            st2_reg <= st2_next;
            cond_prev_reg <= cond_now;
            for (int p = 0; p < NP; p++) begin
                status1_pending[p] <= |st1_next[p];
            end
            signal_loss <= los_reg;
            all_ones_alarm <= ais_reg;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    sequence s_wr_commit(logic [8:0] ri);
        psel && penable && pready && pwrite && idx == ri &&
            port_sel == 3'h0 && paddr[1:0] == 2'b00;
    endsequence

    AST_CTRL_READBACK: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_wr_commit(IDX_BERT_MASK) |=> bmask_reg[0] == $past(pwdata[7:0])
    ) else $error("bert mask did not store written value");

    AST_WM_32: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        fifo_reg[0][1:0] == 2'b10 |=> fifo_wm_bytes[0] == 6'd32
    ) else $error("watermark code 2 not 32 bytes");

    AST_SPARE_VAR: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        spare_reg[0][2:0] == 3'b111 |=> spare_len_var[0] &&
            spare_code_length[0] == 5'd8
    ) else $error("spare code 7 not variable length");

    AST_BERT_FBIT: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !t1_mode[0] |=> !bert_incl_fbit[0]
    ) else $error("f-bit included outside T1 mode");

    AST_LOS_192: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        tick_d2[0] && is_zero[0] && zrun_reg[0] == 8'd191 |=>
            los_reg[0] ##1 st1_reg[0][1] && signal_loss[0]
    ) else $error("loss of signal not raised after 192 zeros");

    AST_Z8_ONCE: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        ev2[0][ST2_Z8_BIT] |=> st2_reg[0][ST2_Z8_BIT] &&
            zrun_reg[0] == 8'd8
    ) else $error("eight-zero event not latched at run of eight");

    AST_LOF_LATCH: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        frame_loss_cond[0] && !cond_prev_reg[0][0] |=> st1_reg[0][0]
    ) else $error("frame loss rise not latched");

    AST_STICKY: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        st1_reg[0][2] && !(wr_go && idx == IDX_STATUS1 && port_sel == 3'h0)
            |=> st1_reg[0][2]
    ) else $error("latched bit dropped without a write");

    AST_NO_ST2_ALERT: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        st1_reg[0] == 8'h00 && ev1[0] == 8'h00 |=> !status1_pending[0]
    ) else $error("pending raised without status one event");

    AST_SEF: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        fbit_tick[0] && fbit_err[0] && |fwin_reg[0][4:0] |=>
            st2_reg[0][ST2_SEF_BIT]
    ) else $error("two errors in six framing bits not latched");

endmodule : rfcs_regs
`default_nettype wire

//--- testbench/rfcs_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// receive line: one bit cell every four cycles, ami marks
module rfcs_line_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic line_en,
    input wire logic bit_val,
    input wire logic viol,
    output logic [1:0] pos,
    output logic [1:0] neg,
    output logic [1:0] tick
);
    logic [1:0] cnt_reg;
    logic alt_reg;
    always_ff @(posedge core_clk) begin
        if (!reset_n || !line_en) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
        end
    end
    // pins held for the whole cell, tick late in the cell
    always_ff @(posedge core_clk) begin
        if (!reset_n || !line_en) begin
            pos <= 2'h0;
            neg <= 2'h0;
            alt_reg <= 1'b0;
        end else if (cnt_reg == 2'h0) begin
            // viol repeats the polarity of the previous mark
            pos <= {2{bit_val & (alt_reg ^ viol)}};
            neg <= {2{bit_val & ~(alt_reg ^ viol)}};
            alt_reg <= alt_reg ^ (bit_val & ~viol);
        end
    end
    always_ff @(posedge core_clk) begin
        tick <= {2{reset_n & line_en & (cnt_reg == 2'h2)}};
    end
endmodule : rfcs_line_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rfcs_pkg::*;
;
    logic core_clk, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, line_en = 0, bit_val = 0, viol = 0;
    logic [1:0] t1_mode = 0, ra_c = 0, fl_c = 0, ft = 0, fe = 0, ac = 0;
    logic [1:0] lp, ln, lt, pend, los, ais, ilv_on, ilv_k, sp_var;
    logic [1:0] h_on, h_fdl, h_sa, b_on, b_dir, b_fb;
    logic [1:0][5:0] wm;
    logic [1:0][4:0] sp_len;
    logic [1:0][7:0] b_use, h_use;
    int fails = 0, n_compared = 0;
    logic [8:0] ci [6] = '{IDX_FIFO_CTRL, IDX_ILV_CTRL, IDX_SPARE_LEN,
        IDX_XPC_CTRL, IDX_BERT_MASK, IDX_HDLC_MASK};
    logic [7:0] cm [6] = '{MASK_FIFO, MASK_ILV, MASK_SPARE, MASK_XPC,
        8'hff, 8'hff};
    logic [7:0] dv [6];
    logic [2:0] p;
    logic t1;
    rfcs_line_model line (.core_clk(core_clk), .reset_n(reset_n),
        .line_en(line_en), .bit_val(bit_val), .viol(viol), .pos(lp),
        .neg(ln),
        .tick(lt));
    rfcs_regs #(.NP(2), .AIS_RUN(16)) dut (.core_clk(core_clk),
        .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .t1_mode(t1_mode), .line_rx_pos(lp), .line_rx_neg(ln),
        .line_bit_tick(lt), .remote_alarm_cond(ra_c),
        .frame_loss_cond(fl_c), .fbit_tick(ft), .fbit_err(fe),
        .align_change(ac), .fifo_wm_bytes(wm), .interleave_on(ilv_on),
        .interleave_kind_sel(ilv_k), .spare_code_length(sp_len),
        .spare_len_var(sp_var), .hdlc256_on(h_on), .hdlc256_fdl(h_fdl),
        .hdlc256_sa(h_sa), .bert_port_on(b_on), .bert_direction(b_dir),
        .bert_incl_fbit(b_fb), .bert_bit_use(b_use),
        .hdlc_bit_use(h_use), .status1_pending(pend),
        .signal_loss(los), .all_ones_alarm(ais));
    // ==========================================================
    // helpers
    function automatic logic [5:0] wm_of(input logic [1:0] c);
        return c == 2'h0 ? 6'h04 : c == 2'h1 ? 6'h10 : c == 2'h2 ? 6'h20 : 6'h30;
    endfunction : wm_of
    function automatic logic [4:0] sp_of(input logic [2:0] c);
        return c == 3'h7 ? 5'h08 : {2'h0, c} + 5'h01;
    endfunction : sp_of
    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [2:0] pt,
        input logic [8:0] i, input logic [7:0] d, input logic [7:0] x,
        input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {pt, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        if (!w) chk("prdata", {24'h0, x}, prdata);
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic send(input logic v, input int n);
        bit_val <= v;
        line_en <= 1'b1;
        repeat (4 * n) @(posedge core_clk);
    endtask : send
    task automatic idle(input int n);
        line_en <= 1'b0;
        ra_c <= ra_c;
        repeat (n) @(posedge core_clk);
    endtask : idle
    task end_of_test;
        if (fails == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        fails++;
        end_of_test;
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'hd42207e7));
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            apb(0, 3'h1, i < 6 ? ci[i] : 9'(IDX_STATUS1 + i - 6), 0, 0, 0);
        end
        apb(1, 3'h0, 9'h08c, 8'hff, 0, 1);
        apb(0, 3'h0, 9'h08c, 0, 0, 1);
        apb(0, 3'h2, IDX_ILV_CTRL, 0, 0, 1);
        for (int it = 0; it < 24; it++) begin
            p = it == 0 ? 3'h0 : 3'($urandom_range(1));
            t1 = 1'($urandom);
            t1_mode <= {t1, t1};
            for (int j = 0; j < 6; j++) begin
                dv[j] = it == 0 ? 8'hff : it == 1 ? 8'h00 : 8'($urandom);
                if (it > 1 && (j == 0 || j == 2)) dv[j][2:0] = 3'(it);
                apb(1, p, ci[j], dv[j], 0, 0);
                apb(0, p, ci[j], 0, dv[j] & cm[j], 0);
            end
            repeat (2) @(posedge core_clk);
            chk("wm", {26'h0, wm_of(dv[0][1:0])}, {26'h0, wm[p]});
            chk("ilv", {30'h0, dv[1][4:3]}, {30'h0, ilv_k[p], ilv_on[p]});
            chk("spare", {26'h0, &dv[2][2:0], sp_of(dv[2][2:0])},
                {26'h0, sp_var[p], sp_len[p]});
            chk("xpc", {26'h0, dv[3][7] & t1, dv[3][7] & ~t1, dv[3][6],
                dv[3][2], dv[3][1] & t1, dv[3][0]}, {26'h0, h_fdl[p],
                h_sa[p], h_on[p], b_dir[p], b_fb[p], b_on[p]});
            chk("masks", {16'h0, ~dv[4], ~dv[5]}, {16'h0, b_use[p], h_use[p]});
        end
        send(0, 191);
        send(0, 1);
        chk("los early", 0, {31'h0, los[0]});
        idle(8);
        chk("los", 32'h3, {30'h0, los});
        apb(0, 3'h1, IDX_STATUS1, 0, 8'h02, 0);
        apb(0, 3'h0, IDX_STATUS2, 0, 8'h18, 0);
        send(1, 15);
        idle(8);
        chk("ais early", 0, {31'h0, ais[0]});
        send(1, 1);
        idle(8);
        chk("ais", 32'h3, {30'h0, ais});
        send(0, 1);
        idle(8);
        apb(0, 3'h0, IDX_STATUS1, 0, 8'h66, 0);
        apb(1, 3'h0, IDX_STATUS1, 8'hff, 0, 0);
        apb(0, 3'h0, IDX_STATUS1, 0, 8'h00, 0);
        apb(0, 3'h1, IDX_STATUS1, 0, 8'h66, 0);
        chk("pending", 32'h2, {30'h0, pend});
        ra_c <= 2'h1;
        fl_c <= 2'h1;
        repeat (4) @(posedge core_clk);
        apb(0, 3'h0, IDX_STATUS1, 0, 8'h09, 0);
        ra_c <= 2'h0;
        fl_c <= 2'h0;
        repeat (4) @(posedge core_clk);
        apb(0, 3'h0, IDX_STATUS1, 0, 8'h99, 0);
        apb(1, 3'h0, IDX_STATUS1, 8'h99, 0, 0);
        apb(1, 3'h0, IDX_STATUS2, 8'hff, 0, 0);
        apb(0, 3'h0, IDX_STATUS2, 0, 8'h00, 0);
        ac <= 2'h1;
        ft <= 2'h1;
        fe <= 2'h1;
        @(posedge core_clk);
        ac <= 2'h0;
        fe <= 2'h0;
        @(posedge core_clk);
        fe <= 2'h1;
        @(posedge core_clk);
        ft <= 2'h0;
        fe <= 2'h0;
        repeat (4) @(posedge core_clk);
        // mark, then 000VB0VB codeword
        send(1, 1);
        send(0, 3);
        viol <= 1'b1;
        send(1, 1);
        viol <= 1'b0;
        send(1, 1);
        send(0, 1);
        viol <= 1'b1;
        send(1, 1);
        viol <= 1'b0;
        send(1, 1);
        idle(8);
        apb(0, 3'h0, IDX_STATUS2, 0, 8'h27, 0);
        chk("pending st2", 32'h2, {30'h0, pend});
        end_of_test;
    end
endmodule : testbench
`default_nettype wire
